// ==== core/qfd_pkg.sv ====
// Constants shared by the queue frame data port
package qfd_pkg;
  // Host byte addresses
  localparam logic [3:0]  ADDR_RX_PTR_CTRL  = 4'h6;
  localparam logic [3:0]  ADDR_DATA_LOW     = 4'h8;
  localparam logic [3:0]  ADDR_DATA_HIGH    = 4'hA;
  // Dword slots selected by host_addr_i[3:2]
  localparam logic [1:0]  SLOT_RX_PTR_CTRL  = ADDR_RX_PTR_CTRL[3:2];
  localparam logic [1:0]  SLOT_DATA         = ADDR_DATA_LOW[3:2];
  // Bit offset where the pointer control word sits in its dword
  localparam int          CTRL_LANE_SHIFT   = 16;
  // rx_read_pointer_control fields
  localparam int          PTR_W             = 11;
  localparam int          RX_AUTO_STEP_BIT  = 14;
  localparam logic [10:0] PTR_RST           = 11'h000;
  localparam logic        AUTO_STEP_RST     = 1'b0;
  // Queue sizes in bytes and their index widths in bits
  localparam int          RXQ_BYTES         = 4096;
  localparam int          RXQ_AW            = 12;
  localparam int          TXQ_BYTES         = 2048;
  localparam int          TXQ_AW            = 11;
  // Host answer latency in clock cycles
  localparam int          ANSWER_CYCLES     = 2;
endpackage

// ==== core/qfd_byte_buffer.sv ====
// Byte-addressed queue memory with four-lane write and registered four-lane read
`timescale 1ns/1ps
module qfd_byte_buffer #(
  parameter int DEPTH = 4096,
  parameter int AW    = 12
) (
  input  wire logic          clk_sys_i,  // System clock
  input  wire logic          rst_i,      // Sync reset, active high
  input  wire logic [3:0]    wr_en_i,    // Lane k writes byte at wr_addr_i+k
  input  wire logic [AW-1:0] wr_addr_i,  // Write start index
  input  wire logic [31:0]   wr_data_i,  // Write bytes, lane 0 first
  input  wire logic [AW-1:0] rd_addr_i,  // Read start index
  output logic      [31:0]   rd_data_o   // Bytes at rd_addr_i+0..3, next cycle
);
  logic [7:0] mem_reg [DEPTH];

  // Indices wrap modulo the depth, so a read near the end continues at the start
  always_ff @(posedge clk_sys_i) begin
    for (int k = 0; k < 4; k++) begin
      if (wr_en_i[k]) begin
        mem_reg[AW'(wr_addr_i + AW'(k))] <= wr_data_i[8*k +: 8];
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_lane
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        rd_data_o[8*g +: 8] <= 8'h00;
      end else begin
        rd_data_o[8*g +: 8] <= mem_reg[AW'(rd_addr_i + AW'(g))];
      end
    end
  end
endmodule

// ==== core/qfd_frame_data_port.sv ====
// Host data port of the receive and transmit frame queues
`timescale 1ns/1ps
module qfd_frame_data_port (
  input  wire logic        clk_sys_i,         // System clock, 125 MHz
  input  wire logic        rst_i,             // Sync reset, active high
  input  wire logic        host_req_i,        // Host access strobe, one cycle
  input  wire logic        host_wr_i,         // 1 write, 0 read
  input  wire logic [3:0]  host_addr_i,       // Byte address; [3:2] picks dword
  input  wire logic [3:0]  host_be_i,         // Byte lanes, contiguous
  input  wire logic [31:0] host_wdata_i,      // Write data by lane
  output logic      [31:0] host_rdata_o,      // Read data by lane
  output logic             host_ack_o,        // Answer pulse
  input  wire logic        rx_fill_en_i,      // Queue manager writes a received byte
  input  wire logic [11:0] rx_fill_addr_i,    // Received byte index
  input  wire logic [7:0]  rx_fill_data_i,    // Received byte
  input  wire logic        rx_release_i,      // Frame release command pulse
  input  wire logic        rx_freed_i,        // Frame memory freed pulse
  input  wire logic [11:0] rx_next_frame_i,   // Next available frame location
  output logic             rx_release_busy_o, // Release pending
  input  wire logic        tx_auto_step_i,    // Transmit auto step bit
  input  wire logic        tx_ptr_load_i,     // Host loads transmit pointer
  input  wire logic [10:0] tx_ptr_value_i,    // Transmit pointer load value
  output logic      [10:0] tx_ptr_o,          // Transmit pointer
  input  wire logic [10:0] tx_drain_addr_i,   // Queue manager read index
  output logic      [31:0] tx_drain_data_o    // Transmit bytes, next cycle
);
  localparam int PW = qfd_pkg::PTR_W;

  function automatic logic [1:0] first_lane(input logic [3:0] be);
    if (be[0]) return 2'd0;
    else if (be[1]) return 2'd1;
    else if (be[2]) return 2'd2;
    else return 2'd3;
  endfunction

  function automatic logic [2:0] lane_count(input logic [3:0] be);
    return 3'(be[0]) + 3'(be[1]) + 3'(be[2]) + 3'(be[3]);
  endfunction

  logic [PW-1:0] rx_ptr_reg;
  logic          rx_auto_reg;
  logic          rx_page_reg;
  logic          busy_reg;
  logic [PW-1:0] tx_ptr_reg;
  logic          s1_valid_reg;
  logic          s1_data_rd_reg;
  logic [1:0]    s1_first_reg;
  logic [31:0]   s1_ctrl_reg;
  logic [31:0]   rx_rd_data;
  logic [3:0]    tx_wr_en;
  logic [31:0]   tx_wr_data;

  logic          data_hit;
  logic          ctrl_hit;
  logic          data_rd;
  logic          data_wr;
  logic          ctrl_wr;
  logic [1:0]    first;
  logic [2:0]    step;
  logic [15:0]   ctrl_word;

  // One dword slot serves both data words; a 16-bit host uses half of it
  assign data_hit  = host_req_i && (host_addr_i[3:2] == qfd_pkg::SLOT_DATA);
  assign ctrl_hit  = host_req_i && (host_addr_i[3:2] == qfd_pkg::SLOT_RX_PTR_CTRL);
  assign data_rd   = data_hit && !host_wr_i;
  assign data_wr   = data_hit && host_wr_i;
  assign ctrl_wr   = ctrl_hit && host_wr_i;
  assign first     = first_lane(host_be_i);
  assign step      = lane_count(host_be_i);
  assign ctrl_word = {1'b0, rx_auto_reg, 3'b000, rx_ptr_reg};

  // Receive pointer: freed frame beats host write beats auto step
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_ptr_reg  <= qfd_pkg::PTR_RST;
      rx_page_reg <= 1'b0;
    end else if (rx_freed_i) begin
      {rx_page_reg, rx_ptr_reg} <= rx_next_frame_i;
    end else if (ctrl_wr) begin
      rx_ptr_reg <= {host_be_i[3] ? host_wdata_i[26:24] : rx_ptr_reg[10:8],
                     host_be_i[2] ? host_wdata_i[23:16] : rx_ptr_reg[7:0]};
    end else if (data_rd && rx_auto_reg) begin
      rx_ptr_reg <= rx_ptr_reg + PW'(step);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_auto_reg <= qfd_pkg::AUTO_STEP_RST;
    end else if (ctrl_wr && host_be_i[3]) begin
      rx_auto_reg <= host_wdata_i[qfd_pkg::CTRL_LANE_SHIFT + qfd_pkg::RX_AUTO_STEP_BIT];
    end
  end

  // A new release request wins over a freed pulse in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
    end else if (rx_release_i) begin
      busy_reg <= 1'b1;
    end else if (rx_freed_i) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_ptr_reg <= qfd_pkg::PTR_RST;
    end else if (tx_ptr_load_i) begin
      tx_ptr_reg <= tx_ptr_value_i;
    end else if (data_wr && tx_auto_step_i) begin
      tx_ptr_reg <= tx_ptr_reg + PW'(step);
    end
  end

  // Lanes are realigned so the lowest enabled lane meets the pointer
  assign tx_wr_en   = data_wr ? (host_be_i >> first) : 4'h0;
  assign tx_wr_data = host_wdata_i >> {first, 3'b000};

  qfd_byte_buffer #(
    .DEPTH (qfd_pkg::RXQ_BYTES),
    .AW    (qfd_pkg::RXQ_AW)
  ) u_rx_queue (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .wr_en_i   ({3'b000, rx_fill_en_i}),
    .wr_addr_i (rx_fill_addr_i),
    .wr_data_i ({24'h00_0000, rx_fill_data_i}),
    .rd_addr_i ({rx_page_reg, rx_ptr_reg}),
    .rd_data_o (rx_rd_data)
  );

  qfd_byte_buffer #(
    .DEPTH (qfd_pkg::TXQ_BYTES),
    .AW    (qfd_pkg::TXQ_AW)
  ) u_tx_queue (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .wr_en_i   (tx_wr_en),
    .wr_addr_i (tx_ptr_reg),
    .wr_data_i (tx_wr_data),
    .rd_addr_i (tx_drain_addr_i),
    .rd_data_o (tx_drain_data_o)
  );

  // Two stages: memory read, then lane shift, so outputs stay registered
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_valid_reg   <= 1'b0;
      s1_data_rd_reg <= 1'b0;
      s1_first_reg   <= 2'd0;
      s1_ctrl_reg    <= 32'h0000_0000;
    end else begin
      s1_valid_reg   <= host_req_i;
      s1_data_rd_reg <= data_rd;
      s1_first_reg   <= first;
      s1_ctrl_reg    <= (ctrl_hit && !host_wr_i) ?
                        {ctrl_word, 16'h0000} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      host_ack_o   <= 1'b0;
      host_rdata_o <= 32'h0000_0000;
    end else begin
      host_ack_o   <= s1_valid_reg;
      host_rdata_o <= s1_data_rd_reg ? (rx_rd_data << {s1_first_reg, 3'b000})
                                     : s1_ctrl_reg;
    end
  end

  assign rx_release_busy_o = busy_reg;
  assign tx_ptr_o          = tx_ptr_reg;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_rx_step_read;
    data_rd && rx_auto_reg && !rx_freed_i;
  endsequence

  sequence s_rx_idle_ptr;
    !rx_auto_reg && !rx_freed_i && !ctrl_wr;
  endsequence

  sequence s_tx_step_write;
    data_wr && tx_auto_step_i && !tx_ptr_load_i;
  endsequence

  chk_rx_auto_step: assert property (
    s_rx_step_read |=> rx_ptr_reg == $past(rx_ptr_reg) + PW'($past(step)))
    else $error("receive pointer did not advance by access width");

  chk_rx_ptr_hold: assert property (
    s_rx_idle_ptr |=> $stable(rx_ptr_reg))
    else $error("receive pointer moved with auto step clear");

  chk_ptr_reset_zero: assert property (
    @(posedge clk_sys_i) disable iff (1'b0)
    rst_i |=> rx_ptr_reg == qfd_pkg::PTR_RST && !rx_auto_reg && tx_ptr_o == 11'h000)
    else $error("pointers not zero after reset");

  chk_release_reload: assert property (
    rx_freed_i |=> {rx_page_reg, rx_ptr_reg} == $past(rx_next_frame_i))
    else $error("pointer not reloaded on freed frame");

  chk_read_answer_time: assert property (
    host_req_i |-> ##2 host_ack_o)
    else $error("host answer not two cycles after request");

  chk_no_spurious_ack: assert property (
    !host_req_i |-> ##2 !host_ack_o)
    else $error("host answer without request");

  chk_tx_write_lane: assert property (
    data_wr && host_be_i != 4'h0 |-> tx_wr_en[0]
      && ((tx_wr_en & (tx_wr_en + 4'h1)) == 4'h0)
      && ($countones(tx_wr_en) == $countones(host_be_i)))
    else $error("transmit write not aligned to pointer");

  chk_tx_auto_step: assert property (
    s_tx_step_write |=> tx_ptr_o == $past(tx_ptr_reg) + PW'($past(step)))
    else $error("transmit pointer did not advance by access width");

  chk_busy_until_freed: assert property (
    rx_release_i ##1 (!rx_freed_i [*2]) |-> rx_release_busy_o)
    else $error("release busy cleared before frame freed");
endmodule

// ==== test/qfd_host_model.sv ====
// Host processor model on the parallel data port bus
`timescale 1ns/1ps
module qfd_host_model (
  input  wire logic        clk_sys_i, // System clock
  input  wire logic        ack_i,     // Answer pulse
  input  wire logic [31:0] rdata_i,   // Read data
  output logic             req_o,     // Access strobe
  output logic             wr_o,      // Write select
  output logic      [3:0]  addr_o,    // Byte address
  output logic      [3:0]  be_o,      // Byte lanes
  output logic      [31:0] wdata_o    // Write data
);
  initial begin
    req_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 4'h0;
    be_o = 4'h0;
    wdata_o = 32'h0000_0000;
  end
  // Strobe is one cycle; qualifiers hold until the answer
  task automatic access(input logic w, input logic [3:0] a, b, input logic [31:0] d,
                        output logic [31:0] q, output bit ok);
    int n;
    ok = 1'b0;
    q = 32'h0000_0000;
    @(negedge clk_sys_i);
    req_o = 1'b1;
    wr_o = w;
    addr_o = a;
    be_o = b;
    wdata_o = d;
    @(negedge clk_sys_i);
    req_o = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      if (ack_i === 1'b1) begin
        q = rdata_i;
        ok = 1'b1;
      end else begin
        @(negedge clk_sys_i);
      end
    end
    // Released data lines must not look like the old value
    wdata_o = ~d;
  endtask
endmodule

// ==== test/test_qfd_frame_data_port.sv ====
// Self-checking bench for the queue frame data port
`timescale 1ns/1ps
module test_qfd_frame_data_port;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req, wr, ack, fill_en, rel, freed, tx_auto, tx_load, busy;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata, drain, q;
  logic [11:0] fill_addr, next_frame;
  logic [7:0]  fill_data;
  logic [10:0] tx_val, tx_ptr, drain_addr;
  int          n_mismatch = 0;
  int          n_tests = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  qfd_frame_data_port dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .host_req_i(req),
    .host_wr_i(wr), .host_addr_i(addr), .host_be_i(be), .host_wdata_i(wdata),
    .host_rdata_o(rdata), .host_ack_o(ack), .rx_fill_en_i(fill_en),
    .rx_fill_addr_i(fill_addr), .rx_fill_data_i(fill_data), .rx_release_i(rel),
    .rx_freed_i(freed), .rx_next_frame_i(next_frame), .rx_release_busy_o(busy),
    .tx_auto_step_i(tx_auto), .tx_ptr_load_i(tx_load), .tx_ptr_value_i(tx_val),
    .tx_ptr_o(tx_ptr), .tx_drain_addr_i(drain_addr), .tx_drain_data_o(drain));
  qfd_host_model host (.clk_sys_i(clk_sys_i), .ack_i(ack), .rdata_i(rdata), .req_o(req),
    .wr_o(wr), .addr_o(addr), .be_o(be), .wdata_o(wdata));
  function automatic logic [7:0] rxb(input int i);
    return 8'(i) ^ 8'h5A;
  endfunction
  task automatic close_out;
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, m);
    n_tests++;
    if ((got & m) !== (exp & m)) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, b, input logic [31:0] d);
    bit ok;
    host.access(w, a, b, d, q, ok);
    if (!ok) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      close_out();
    end
  endtask
  task automatic set_ptr(input logic auto_on, input logic [10:0] p);
    acc(1'b1, qfd_pkg::ADDR_RX_PTR_CTRL, 4'hC, {1'b0, auto_on, 3'b000, p, 16'h0000});
  endtask
  task automatic rd_ctrl(input logic [15:0] e);
    acc(1'b0, qfd_pkg::ADDR_RX_PTR_CTRL, 4'hC, 32'h0000_0000);
    chk(q, {e, 16'h0000}, 32'hFFFF_0000);
  endtask
  task automatic t_reset;
    rd_ctrl(16'h0000);
    acc(1'b0, 4'h0, 4'hF, 32'h0000_0000);
    chk(q, 32'h0000_0000, 32'hFFFF_FFFF);
  endtask
  // Bytes just below the pointer limit and at the bottom of the queue
  task automatic t_fill;
    for (int k = -2; k < 8; k++) begin
      @(negedge clk_sys_i);
      fill_en = 1'b1;
      fill_addr = 12'(k & 32'h0000_07FF);
      fill_data = rxb(k & 32'h0000_07FF);
    end
    @(negedge clk_sys_i);
    fill_en = 1'b0;
  endtask
  task automatic t_auto;
    set_ptr(1'b1, 11'h7FE);
    acc(1'b0, qfd_pkg::ADDR_DATA_LOW, 4'h3, 32'h0000_0000);
    chk(q, {16'h0000, rxb(12'h7FF), rxb(12'h7FE)}, 32'h0000_FFFF);
    acc(1'b0, qfd_pkg::ADDR_DATA_LOW, 4'h1, 32'h0000_0000);
    chk(q, {24'h00_0000, rxb(0)}, 32'h0000_00FF);
    acc(1'b0, qfd_pkg::ADDR_DATA_LOW, 4'hF, 32'h0000_0000);
    chk(q, {rxb(4), rxb(3), rxb(2), rxb(1)}, 32'hFFFF_FFFF);
    acc(1'b0, qfd_pkg::ADDR_DATA_HIGH, 4'hC, 32'h0000_0000);
    chk(q, {rxb(6), rxb(5), 16'h0000}, 32'hFFFF_0000);
    rd_ctrl(16'h4007);
  endtask
  task automatic t_manual;
    set_ptr(1'b0, 11'h003);
    repeat (2) begin
      acc(1'b0, qfd_pkg::ADDR_DATA_LOW, 4'hF, 32'h0000_0000);
      chk(q, {rxb(6), rxb(5), rxb(4), rxb(3)}, 32'hFFFF_FFFF);
    end
    rd_ctrl(16'h0003);
  endtask
  task automatic t_release;
    @(negedge clk_sys_i);
    rel = 1'b1;
    @(negedge clk_sys_i);
    rel = 1'b0;
    // Busy must stand while the freed pulse is late
    repeat (3) begin
      chk(32'(busy), 32'h0000_0001, 32'h0000_0001);
      @(negedge clk_sys_i);
    end
    next_frame = 12'h123;
    freed = 1'b1;
    @(negedge clk_sys_i);
    freed = 1'b0;
    chk(32'(busy), 32'h0000_0000, 32'h0000_0001);
    // New release in the freed cycle: the set wins
    @(negedge clk_sys_i);
    {rel, freed} = 2'b11;
    @(negedge clk_sys_i);
    rel = 1'b0;
    chk(32'(busy), 32'h0000_0001, 32'h0000_0001);
    @(negedge clk_sys_i);
    freed = 1'b0;
    chk(32'(busy), 32'h0000_0000, 32'h0000_0001);
    rd_ctrl(16'h0123);
  endtask
  task automatic t_tx;
    tx_auto = 1'b1;
    tx_val = 11'h010;
    @(negedge clk_sys_i);
    tx_load = 1'b1;
    @(negedge clk_sys_i);
    tx_load = 1'b0;
    acc(1'b1, qfd_pkg::ADDR_DATA_LOW, 4'h3, 32'h0000_BEEF);
    chk(32'(tx_ptr), 32'h0000_0012, 32'h0000_07FF);
    acc(1'b1, qfd_pkg::ADDR_DATA_HIGH, 4'h4, 32'h0077_0000);
    chk(32'(tx_ptr), 32'h0000_0013, 32'h0000_07FF);
    drain_addr = 11'h010;
    @(negedge clk_sys_i);
    chk(drain, 32'h0077_BEEF, 32'h00FF_FFFF);
  endtask
  initial begin
    {fill_en, rel, freed, tx_auto, tx_load} = 5'b00000;
    fill_addr = 12'h000;
    fill_data = 8'h00;
    next_frame = 12'h000;
    tx_val = 11'h000;
    drain_addr = 11'h000;
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    t_reset();
    t_fill();
    t_auto();
    t_manual();
    t_release();
    t_tx();
    close_out();
  end
endmodule
